// File: design/dsf_cmd.sv
// Special-function command decoder and control register of a 40-channel DAC.
// Assumes cmd_valid is a one-cycle strobe on clk_sys carrying a framed command;
// pin inputs (hardware power-down, overtemperature, load strobe) are asynchronous.
`timescale 1ns/100ps
module dsf_cmd
    import dsf_pkg::*;
#(
    parameter int          PWRUP_CYCLES = dsf_pkg::PWRUP_CYC,
    parameter int          SRST_CYCLES  = dsf_pkg::SRST_CYC,
    parameter logic        REF_LVL_DFLT = 1'b1,
    parameter int          NUM_CH       = 40
)
(
    input  wire logic                        clk_sys,
    input  wire logic                        rst_n,
    input  wire logic                        cmd_valid,
    input  wire logic                        cmd_read,
    input  wire logic                        register_select_high,
    input  wire logic                        register_select_low,
    input  wire logic [dsf_pkg::CMD_W-1:0]   channel_address_bits,
    input  wire logic [dsf_pkg::DATA_W-1:0]  data_field_bits,
    input  wire logic                        hw_powerdown,
    input  wire logic                        over_temp,
    input  wire logic                        load_dac_strobe,
    output logic                             wr_reject,
    output logic                             rd_valid,
    output logic [dsf_pkg::DATA_W-1:0]       rd_data,
    output logic                             busy_n,
    output logic                             powerdown,
    output logic                             amp_off,
    output logic                             pd_output_hiz,
    output logic                             ref_2v5,
    output logic                             amp_boost,
    output logic                             ref_internal,
    output logic                             monitor_mode,
    output logic [dsf_pkg::CMD_W-1:0]        monitor_channel,
    output logic                             monitor_tristate,
    output logic                             soft_reset_pulse,
    output logic [39:0]                      toggle_sel_b
);
    import dsf_pkg::*;

    dsf_timer_if tmr ();
    dsf_timer u_timer
    (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .tmr     (tmr)
    );

    function automatic logic [DATA_W-1:0] ctrl_default(input logic lvl);
        logic [DATA_W-1:0] v;
        v              = CTRL_RST_BASE;
        v[BIT_REF_LVL] = lvl;
        return v;
    endfunction : ctrl_default

    // Power-on and soft reset share one default, so the variant's reference level holds
    localparam logic [DATA_W-1:0] CTRL_DFLT = ctrl_default(REF_LVL_DFLT);

    // Two-flop synchronisers for the asynchronous pins
    logic [2:0] sync1_ff;
    logic [2:0] sync2_ff;
    logic       load_dac_strobe_prev_ff;
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sync1_ff     <= 3'h0;
            sync2_ff     <= 3'h0;
            load_dac_strobe_prev_ff <= 1'b0;
        end
        else
        begin
            sync1_ff     <= {load_dac_strobe, over_temp, hw_powerdown};
            sync2_ff     <= sync1_ff;
            load_dac_strobe_prev_ff <= sync2_ff[2];
        end
    end
    wire hw_pd_s  = sync2_ff[0];
    wire hot_s    = sync2_ff[1];
    wire load_dac_strobe_s   = sync2_ff[2];
    wire load_dac_strobe_rise = load_dac_strobe_s && !load_dac_strobe_prev_ff;

    // State
    dsf_state_e        state_ff;
    dsf_state_e        nxt_state;
    logic              sw_pd_ff;
    logic              therm_trip_ff;
    logic [DATA_W-1:0] ctrl_ff;
    logic [CMD_W-1:0]  mon_ff;
    logic [GROUPS-1:0] tgl_phase_ff;

    // Decode
    wire is_sfr     = ({register_select_high, register_select_low} == SEL_SFR); // [RQ1]
    wire sfr_cmd    = cmd_valid && is_sfr && (state_ff != DSF_RESET);
    wire c_pd       = sfr_cmd && (channel_address_bits == CMD_PWR_DOWN);       // [RQ2]
    wire c_pu       = sfr_cmd && (channel_address_bits == CMD_PWR_UP);         // [RQ4]
    wire c_mon      = sfr_cmd && (channel_address_bits == CMD_MON_SEL);
    wire c_ctrl     = sfr_cmd && (channel_address_bits == CMD_CTRL);
    wire c_rst      = sfr_cmd && (channel_address_bits == CMD_SOFT_RST);
    wire eff_pd     = hw_pd_s || sw_pd_ff;                                     // [RQ5]
    // Reads stay allowed in power-down since they leave state untouched
    wire c_rd       = c_ctrl && cmd_read;                                      // [RQ9]
    wire wr_try     = (c_ctrl && !cmd_read) || c_mon || c_rst;
    wire wr_block   = wr_try && eff_pd;                                        // [RQ3]
    wire do_ctrl_wr = c_ctrl && !cmd_read && !eff_pd;                          // [RQ9]
    wire do_mon_wr  = c_mon && !eff_pd;
    // Soft reset in power-down is the host's fault; it is refused, not half-run
    wire do_rst     = c_rst && !eff_pd;                                        // [RQ8]
    wire therm_hit  = ctrl_ff[BIT_THERM_EN] && hot_s;                          // [RQ15]

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            DSF_IDLE:
            begin
                if (do_rst)
                    nxt_state = DSF_RESET;
                else if (c_pu && sw_pd_ff)
                    nxt_state = DSF_WAKE;
            end
            DSF_WAKE:
            begin
                if (c_pd)
                    nxt_state = DSF_IDLE;
                else if (tmr.done)
                    nxt_state = DSF_IDLE;
            end
            DSF_RESET:
            begin
                if (tmr.done)
                    nxt_state = DSF_IDLE;
            end
            default: nxt_state = DSF_IDLE;
        endcase
    end

    assign tmr.start = (state_ff == DSF_IDLE) && (do_rst || (c_pu && sw_pd_ff));
    assign tmr.count = do_rst ? SRST_CYCLES : PWRUP_CYCLES;                    // [RQ4] [RQ7]

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            state_ff <= DSF_IDLE;
        else
            state_ff <= nxt_state;
    end

    // Power-down state; the wake sequence holds the amplifiers off until it ends
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sw_pd_ff      <= 1'b0;
            therm_trip_ff <= 1'b0;
        end
        else
        begin
            if (c_pd)
                sw_pd_ff <= 1'b1;                                              // [RQ2]
            else if (state_ff == DSF_WAKE && tmr.done)
                sw_pd_ff <= 1'b0;                                              // [RQ4]
            if (therm_hit)
                therm_trip_ff <= 1'b1;                                         // [RQ15]
            else if (c_pu)
                therm_trip_ff <= 1'b0;                                         // [RQ15]
        end
    end

    // Control register, monitor address and toggle phases
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_ff      <= CTRL_DFLT;                                         // [RQ11]
            mon_ff       <= MON_RST;
            tgl_phase_ff <= '0;
        end
        else if (do_rst)
        begin
            ctrl_ff      <= CTRL_DFLT;                                         // [RQ6]
            mon_ff       <= MON_RST;
            tgl_phase_ff <= '0;
        end
        else
        begin
            if (do_ctrl_wr)
                ctrl_ff <= data_field_bits & CTRL_WR_MASK;                     // [RQ16]
            if (do_mon_wr)
                mon_ff <= data_field_bits[DATA_W-1 -: CMD_W];                  // [RQ18]
            if (load_dac_strobe_rise && state_ff != DSF_RESET)
                tgl_phase_ff <= tgl_phase_ff ^ ctrl_ff[TGL_LSB +: GROUPS];     // [RQ17]
        end
    end

    wire [39:0] tgl_w;
    genvar g;
    generate
        for (g = 0; g < GROUPS; g++)
        begin : gen_tgl
            assign tgl_w[g*8 +: 8] = {8{tgl_phase_ff[g] & ctrl_ff[TGL_LSB + g]}}; // [RQ16]
        end
    endgenerate

    wire mon_on = ctrl_ff[BIT_MON_EN];                                         // [RQ14]

    // Registered outputs
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_reject        <= 1'b0;
            rd_valid         <= 1'b0;
            rd_data          <= '0;
            busy_n           <= 1'b1;
            powerdown        <= 1'b0;
            amp_off          <= 1'b0;
            pd_output_hiz    <= 1'b1;
            ref_2v5          <= REF_LVL_DFLT;
            amp_boost        <= 1'b0;
            ref_internal     <= 1'b0;
            monitor_mode     <= 1'b0;
            monitor_channel  <= MON_RST;
            monitor_tristate <= 1'b1;
            soft_reset_pulse <= 1'b0;
            toggle_sel_b     <= '0;
        end
        else
        begin
            wr_reject        <= wr_block;                                      // [RQ3]
            rd_valid         <= c_rd;                                          // [RQ9]
            rd_data          <= c_rd ? ctrl_ff : rd_data;
            busy_n           <= (nxt_state != DSF_RESET);                      // [RQ7]
            powerdown        <= eff_pd;                                        // [RQ5]
            amp_off          <= eff_pd || therm_trip_ff;                       // [RQ15]
            pd_output_hiz    <= ctrl_ff[BIT_PD_HIZ];                           // [RQ10]
            ref_2v5          <= ctrl_ff[BIT_REF_LVL];                          // [RQ11]
            amp_boost        <= ctrl_ff[BIT_BOOST];                            // [RQ12]
            ref_internal     <= ctrl_ff[BIT_REF_INT];                          // [RQ13]
            monitor_mode     <= mon_on;                                        // [RQ14]
            monitor_channel  <= mon_ff;                                        // [RQ20]
            monitor_tristate <= !mon_on || (mon_ff == MON_TRISTATE);           // [RQ20]
            soft_reset_pulse <= do_rst;                                        // [RQ6]
            toggle_sel_b     <= tgl_w;                                         // [RQ17]
        end
    end

endmodule : dsf_cmd

// File: design/dsf_pkg.sv
// Constants for the DAC special-function command decoder.
// Assumes one 200 MHz clock and command words delivered already framed.
//
// Contract
// RQ1 - Register-select bits both zero pick special functions; address bits hold the code.
// RQ2 - Code 001000 enters global power-down, data ignored.
// RQ3 - In power-down registers keep contents and all writes are rejected.
// RQ4 - Code 001001 powers up amplifiers and reference within 8 us.
// RQ5 - Effective power-down is hardware pin OR software state.
// RQ6 - Code 001111 restores defaults and clears DAC registers to zero volts.
// RQ7 - Software reset takes 135 us to complete.
// RQ8 - Host issues software reset only outside power-down.
// RQ9 - Code 001100 writes control register when read bit 0, reads when 1.
// RQ10 - Bit 11 sets power-down output: 1 high impedance, 0 load to ground.
// RQ11 - Bit 10 selects internal reference 2.5 V when 1, 1.25 V when 0.
// RQ12 - Bit 9 enables amplifier boost; off by default.
// RQ13 - Bit 8 enables internal reference; external by default.
// RQ14 - Bit 7 enables monitoring, turning channel 39 pin into monitor output.
// RQ15 - Bit 6 lets overtemperature power down amplifiers; soft power-up re-enables.
// RQ16 - Bits 4 to 0 enable toggle per eight-channel group; bit 5 ignored.
// RQ17 - In toggle groups each load strobe swaps between A and B registers.
// RQ18 - Code 001010 takes data bits 11 to 6 as monitored channel.
// RQ19 - Host sets monitor enable before selecting a monitor channel.
// RQ20 - Monitor 0 to 38 routes channel, 63 three-states, others undefined.
package dsf_pkg;
    localparam int          CMD_W         = 6;
    localparam int          DATA_W        = 12;
    localparam int          GROUPS        = 5;
    localparam logic [5:0]  CMD_PWR_DOWN  = 6'h08;
    localparam logic [5:0]  CMD_PWR_UP    = 6'h09;
    localparam logic [5:0]  CMD_MON_SEL   = 6'h0a;
    localparam logic [5:0]  CMD_CTRL      = 6'h0c;
    localparam logic [5:0]  CMD_SOFT_RST  = 6'h0f;
    localparam logic [1:0]  SEL_SFR       = 2'h0;
    localparam int          BIT_PD_HIZ    = 11;
    localparam int          BIT_REF_LVL   = 10;
    localparam int          BIT_BOOST     = 9;
    localparam int          BIT_REF_INT   = 8;
    localparam int          BIT_MON_EN    = 7;
    localparam int          BIT_THERM_EN  = 6;
    localparam int          TGL_LSB       = 0;
    localparam logic [11:0] CTRL_RST_BASE = 12'h800;
    localparam logic [11:0] CTRL_WR_MASK  = 12'hfdf;
    localparam logic [5:0]  MON_LAST_CH   = 6'h26;
    localparam logic [5:0]  MON_TRISTATE  = 6'h3f;
    localparam logic [5:0]  MON_RST       = 6'h3f;
    localparam int          CLK_MHZ       = 200;
    localparam int          PWRUP_US      = 8;
    localparam int          SRST_US       = 135;
    localparam int          PWRUP_CYC     = PWRUP_US * CLK_MHZ;
    localparam int          SRST_CYC      = SRST_US * CLK_MHZ;
    typedef enum logic [1:0] {DSF_IDLE, DSF_WAKE, DSF_RESET} dsf_state_e;
endpackage : dsf_pkg

// File: design/dsf_timer.sv
// Down-counter that pulses done once a loaded cycle count has elapsed.
// Assumes start is a one-cycle pulse; a new start reloads.
`timescale 1ns/100ps
module dsf_timer
(
    input  wire logic     clk_sys,
    input  wire logic     rst_n,
    dsf_timer_if.timer    tmr
);
    logic [31:0] cnt_ff;
    logic        run_ff;
    logic        done_ff;
    wire         last_w = run_ff && (cnt_ff <= 32'h1);
    assign tmr.done = done_ff;
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_ff  <= 32'h0;
            run_ff  <= 1'b0;
            done_ff <= 1'b0;
        end
        else
        begin
            done_ff <= !tmr.start && last_w;
            run_ff  <= tmr.start || (run_ff && !last_w);
            cnt_ff  <= tmr.start ? tmr.count : cnt_ff - 32'h1;
        end
    end
endmodule : dsf_timer

// File: design/dsf_timer_if.sv
// Start and done handshake between the decoder and its delay timer.
// Assumes both ends share clk_sys.
`timescale 1ns/100ps
interface dsf_timer_if;
    logic        start;
    logic [31:0] count;
    logic        done;
    modport ctrl  (output start, output count, input done);
    modport timer (input start, input count, output done);
endinterface : dsf_timer_if

// File: tb/dsf_cmd_assertions.sv
// Port-level checks of the special-function command decoder.
// Assumes it is bound onto dsf_cmd; one clock domain, clk_sys.
`timescale 1ns/100ps
module dsf_cmd_assertions
    import dsf_pkg::*;
#(
    parameter int SRST_CYCLES = 50
)
(
    input wire logic                        clk_sys,
    input wire logic                        rst_n,
    input wire logic                        cmd_valid,
    input wire logic                        cmd_read,
    input wire logic                        register_select_high,
    input wire logic                        register_select_low,
    input wire logic [dsf_pkg::CMD_W-1:0]   channel_address_bits,
    input wire logic [dsf_pkg::DATA_W-1:0]  data_field_bits,
    input wire logic                        hw_powerdown,
    input wire logic                        wr_reject,
    input wire logic                        rd_valid,
    input wire logic [dsf_pkg::DATA_W-1:0]  rd_data,
    input wire logic                        busy_n,
    input wire logic                        powerdown,
    input wire logic                        pd_output_hiz,
    input wire logic                        ref_2v5,
    input wire logic                        amp_boost,
    input wire logic                        ref_internal,
    input wire logic                        monitor_mode,
    input wire logic [dsf_pkg::CMD_W-1:0]   monitor_channel,
    input wire logic                        monitor_tristate,
    input wire logic                        soft_reset_pulse
);
    default clocking dcb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    int unsigned low_cnt_ff;
    // Counter, not a repetition: the real reset time runs to tens of thousands of cycles
    always_ff @(posedge clk_sys or negedge rst_n)
        if (!rst_n)
            low_cnt_ff <= 0;
        else
            low_cnt_ff <= busy_n ? 0 : low_cnt_ff + 1;
    sequence sfr_cmd(logic [5:0] code);
        cmd_valid && !register_select_high && !register_select_low
            && channel_address_bits == code && busy_n;
    endsequence
    sequence sfr_write(logic [5:0] code);
        sfr_cmd(code) ##0 (!cmd_read && !powerdown);
    endsequence
    sel_filter_a: assert property (
        cmd_valid && (register_select_high || register_select_low)
        |=> !rd_valid && !wr_reject && !soft_reset_pulse) else $error("Non-special word acted on");
    pwr_down_a: assert property (
        sfr_cmd(CMD_PWR_DOWN) |-> ##2 powerdown) else $error("Power-down not entered");
    pd_refuse_a: assert property (
        sfr_cmd(CMD_CTRL) ##0 (!cmd_read && powerdown) |=> wr_reject)
        else $error("Write not refused");
    hw_pd_a: assert property (
        hw_powerdown [*5] |-> powerdown) else $error("Pin power-down ignored");
    srst_start_a: assert property (
        sfr_write(CMD_SOFT_RST) |=> soft_reset_pulse && !busy_n)
        else $error("Soft reset not started");
    srst_time_a: assert property (
        $rose(busy_n) |-> low_cnt_ff >= SRST_CYCLES - 2 && low_cnt_ff <= SRST_CYCLES + 2)
        else $error("Soft reset length wrong");
    ctrl_wr_a: assert property (
        sfr_write(CMD_CTRL) |-> ##2 {pd_output_hiz, ref_2v5, amp_boost, ref_internal,
        monitor_mode} == $past(data_field_bits[11:7], 2)) else $error("Control write lost");
    ctrl_rd_a: assert property (
        sfr_cmd(CMD_CTRL) ##0 cmd_read |=> rd_valid && rd_data[11:7] == {pd_output_hiz,
        ref_2v5, amp_boost, ref_internal, monitor_mode}) else $error("Control read wrong");
    mon_sel_a: assert property (
        sfr_write(CMD_MON_SEL) |-> ##2 monitor_channel == $past(data_field_bits[11:6], 2))
        else $error("Monitor address wrong");
    mon_tri_a: assert property (
        monitor_channel == MON_TRISTATE |-> ##[0:1] monitor_tristate)
        else $error("Monitor driven");
endmodule : dsf_cmd_assertions

bind dsf_cmd dsf_cmd_assertions #(.SRST_CYCLES(SRST_CYCLES)) chk_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_read(cmd_read),
    .register_select_high(register_select_high), .register_select_low(register_select_low),
    .channel_address_bits(channel_address_bits), .data_field_bits(data_field_bits),
    .hw_powerdown(hw_powerdown), .wr_reject(wr_reject), .rd_valid(rd_valid),
    .rd_data(rd_data), .busy_n(busy_n), .powerdown(powerdown), .pd_output_hiz(pd_output_hiz),
    .ref_2v5(ref_2v5), .amp_boost(amp_boost), .ref_internal(ref_internal),
    .monitor_mode(monitor_mode), .monitor_channel(monitor_channel),
    .monitor_tristate(monitor_tristate), .soft_reset_pulse(soft_reset_pulse));

// File: tb/dsf_host_model.sv
// Host controller model issuing framed special-function command words.
// Assumes clk_sys is shared with the decoder; drives just after rising edges.
`timescale 1ns/100ps
module dsf_host_model
    import dsf_pkg::*;
(
    input  wire logic                        clk_sys,
    input  wire logic                        powerdown,
    output logic                             cmd_valid,
    output logic                             cmd_read,
    output logic                             register_select_high,
    output logic                             register_select_low,
    output logic [dsf_pkg::CMD_W-1:0]        channel_address_bits,
    output logic [dsf_pkg::DATA_W-1:0]       data_field_bits
);
    initial
        {cmd_valid, cmd_read, register_select_high, register_select_low,
            channel_address_bits, data_field_bits} = '0;
    task issue(input logic [1:0] sel, input logic rd, input logic [5:0] code,
               input logic [11:0] data);
        if (code == CMD_SOFT_RST && powerdown)
            return;
        @(posedge clk_sys);
        cmd_valid <= 1'b1;
        cmd_read <= rd;
        {register_select_high, register_select_low} <= sel;
        channel_address_bits <= code;
        data_field_bits <= data;
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
        // Lines flip once released so a stale word is never mistaken for a live one
        channel_address_bits <= ~code;
        data_field_bits <= ~data;
    endtask : issue
endmodule : dsf_host_model

// File: tb/test_dac_special_function_commands.sv
// Self-checking bench for the special-function command decoder.
// Assumes short wake and reset counts (20 and 50 cycles) for run time.
`timescale 1ns/100ps
module test_dac_special_function_commands;
    import dsf_pkg::*;
    logic clk_sys, rst_n, hw_powerdown, over_temp, load_dac_strobe, cmd_valid, cmd_read;
    logic register_select_high, register_select_low, wr_reject, rd_valid, busy_n, powerdown;
    logic amp_off, pd_output_hiz, ref_2v5, amp_boost, ref_internal, monitor_mode;
    logic monitor_tristate, soft_reset_pulse;
    logic [5:0]  channel_address_bits, monitor_channel;
    logic [11:0] data_field_bits, rd_data;
    logic [39:0] toggle_sel_b;
    int          fail_count, checks_done;
    dsf_cmd #(.PWRUP_CYCLES(20), .SRST_CYCLES(50), .REF_LVL_DFLT(1'b1), .NUM_CH(40)) uut (
        .clk_sys(clk_sys), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_read(cmd_read),
        .register_select_high(register_select_high), .register_select_low(register_select_low),
        .channel_address_bits(channel_address_bits), .data_field_bits(data_field_bits),
        .hw_powerdown(hw_powerdown), .over_temp(over_temp), .load_dac_strobe(load_dac_strobe),
        .wr_reject(wr_reject), .rd_valid(rd_valid), .rd_data(rd_data), .busy_n(busy_n),
        .powerdown(powerdown), .amp_off(amp_off), .pd_output_hiz(pd_output_hiz),
        .ref_2v5(ref_2v5), .amp_boost(amp_boost), .ref_internal(ref_internal),
        .monitor_mode(monitor_mode), .monitor_channel(monitor_channel),
        .monitor_tristate(monitor_tristate), .soft_reset_pulse(soft_reset_pulse),
        .toggle_sel_b(toggle_sel_b));
    dsf_host_model host (
        .clk_sys(clk_sys), .powerdown(powerdown), .cmd_valid(cmd_valid), .cmd_read(cmd_read),
        .register_select_high(register_select_high), .register_select_low(register_select_low),
        .channel_address_bits(channel_address_bits), .data_field_bits(data_field_bits));
    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    task complete_run;
        $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : complete_run
    task chk(input logic [39:0] seen, input logic [39:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    function automatic logic pick(input int i);
        return i == 0 ? powerdown : i == 1 ? amp_off : busy_n;
    endfunction : pick
    task wait_for(input int i, input logic v, input int n);
        int k;
        for (k = 0; k < n && pick(i) !== v; k++)
            @(posedge clk_sys) #1;
        if (pick(i) !== v)
        begin
            fail_count++;
            $display("MISMATCH t=%0t wait ran out", $time);
            complete_run();
        end
    endtask : wait_for
    task settle;
        repeat (2) @(posedge clk_sys);
        #1;
    endtask : settle
    task wr(input logic [11:0] d);
        host.issue(2'h0, 1'b0, CMD_CTRL, d);
    endtask : wr
    task rd(input logic [11:0] exp);
        host.issue(2'h0, 1'b1, CMD_CTRL, 12'h000);
        #1;
        chk(rd_valid, 1'b1);
        chk(rd_data, exp);
    endtask : rd
    task s_reset;
        chk({pd_output_hiz, amp_boost, ref_internal, monitor_mode}, 4'h8);
        chk(ref_2v5, 1'b1);
        chk({monitor_channel, monitor_tristate}, {MON_TRISTATE, 1'b1});
        rd(12'hc00);
    endtask : s_reset
    task s_ctrl;
        logic [11:0] v [3] = '{12'hfff, 12'h000, 12'h6aa};
        foreach (v[i])
        begin
            wr(v[i]);
            settle();
            chk({pd_output_hiz, ref_2v5, amp_boost, ref_internal, monitor_mode},
                v[i][11:7]);
            rd(v[i] & 12'hfdf);
        end
        host.issue(2'h3, 1'b0, CMD_CTRL, 12'h000);
        rd(12'h68a);
    endtask : s_ctrl
    task s_toggle;
        wr(12'h031);
        for (int n = 1; n <= 2; n++)
        begin
            @(posedge clk_sys) load_dac_strobe <= 1'b1;
            repeat (3) @(posedge clk_sys);
            load_dac_strobe <= 1'b0;
            settle();
            repeat (3) @(posedge clk_sys);
            #1;
            chk(toggle_sel_b, n == 1 ? 40'hff000000ff : 40'h0);
        end
    endtask : s_toggle
    task s_monitor;
        logic [5:0] m [3] = '{6'h00, 6'h26, 6'h3f};
        wr(12'h080);
        foreach (m[i])
        begin
            host.issue(2'h0, 1'b0, CMD_MON_SEL, {m[i], 6'h15});
            settle();
            chk({monitor_channel, monitor_tristate}, {m[i], m[i] == 6'h3f});
        end
    endtask : s_monitor
    task s_power;
        host.issue(2'h0, 1'b0, CMD_PWR_DOWN, 12'hfff);
        settle();
        chk({powerdown, amp_off}, 2'h3);
        wr(12'h000);
        #1;
        chk(wr_reject, 1'b1);
        rd(12'h080);
        host.issue(2'h0, 1'b0, CMD_PWR_UP, 12'h000);
        repeat (15) @(posedge clk_sys);
        #1;
        chk(powerdown, 1'b1);
        wait_for(0, 1'b0, 20);
        @(posedge clk_sys) hw_powerdown <= 1'b1;
        wait_for(0, 1'b1, 6);
        wr(12'h000);
        #1;
        chk(wr_reject, 1'b1);
        @(posedge clk_sys) hw_powerdown <= 1'b0;
        wait_for(0, 1'b0, 40);
    endtask : s_power
    task s_thermal;
        wr(12'h040);
        @(posedge clk_sys) over_temp <= 1'b1;
        wait_for(1, 1'b1, 8);
        chk(powerdown, 1'b0);
        @(posedge clk_sys) over_temp <= 1'b0;
        settle();
        chk(amp_off, 1'b1);
        host.issue(2'h0, 1'b0, CMD_PWR_UP, 12'h000);
        wait_for(1, 1'b0, 40);
    endtask : s_thermal
    task s_srst;
        wr(12'h3ff);
        host.issue(2'h0, 1'b0, CMD_SOFT_RST, 12'h000);
        #1;
        chk({soft_reset_pulse, busy_n}, 2'h2);
        wr(12'h0ff);
        repeat (38) @(posedge clk_sys);
        #1;
        chk(busy_n, 1'b0);
        wait_for(2, 1'b1, 20);
        rd(12'hc00);
    endtask : s_srst
    initial
    begin
        {hw_powerdown, over_temp, load_dac_strobe} = 3'h0;
        rst_n = 1'b0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys) #1;
        s_reset();
        s_ctrl();
        s_toggle();
        s_monitor();
        s_power();
        s_thermal();
        s_srst();
        complete_run();
    end
endmodule : test_dac_special_function_commands
